/* scotp_autozero_decode.sv */
/*
 * Decoder of the auto-zero selection field into enable, sync source and
 * charge pump clock gating. Pure combinational; fed from a register, outputs unregistered.
 */
module scotp_autozero_decode
   import scotp_pkg::*;
(
   // Selection
   input wire logic [1:0] i_sel,
   // Decoded controls
   output logic o_enable,
   output logic o_ext_sync,
   output logic o_cp_gate
);

   // ****************************************
   // Decode
   // ****************************************
   always_comb begin
      o_enable = 1'b1;
      o_ext_sync = 1'b0;
      o_cp_gate = 1'b0;
      case (i_sel)
         AZ_INT_SYNC: begin
         end
         AZ_OFF: begin
            o_enable = 1'b0;
         end
         AZ_EXT_SYNC: begin
            o_ext_sync = 1'b1;
         end
         AZ_EXT_CPGATE: begin
            o_ext_sync = 1'b1;
            o_cp_gate = 1'b1;
         end
         default: begin
            o_enable = 1'b0;
         end
      endcase
   end

endmodule : scotp_autozero_decode

/* scotp_host.sv */
/* Host model driving the decoded register port.
   Assumes requests are taken on rising i_mclk. */
module scotp_host (
   input wire logic i_mclk,
   output logic i_wr_en,
   output logic i_rd_en,
   output logic [5:0] i_addr,
   output logic [15:0] i_wdata,
   input wire logic [15:0] o_rdata,
   input wire logic o_rvalid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      i_wr_en = 1'b0;
      i_rd_en = 1'b0;
      i_addr = 6'h00;
      i_wdata = 16'h0000;
   end
   // Programming is only ever started by this write
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(negedge i_mclk);
      i_wr_en = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(negedge i_mclk);
      i_wr_en = 1'b0;
      // Released lines invert so stale values never match
      i_addr = ~a;
      i_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic ok);
      int n;
      @(negedge i_mclk);
      i_rd_en = 1'b1;
      i_addr = a;
      @(negedge i_mclk);
      i_rd_en = 1'b0;
      i_addr = ~a;
      for (n = 0; n < 4 && o_rvalid !== 1'b1; n++) begin
         @(negedge i_mclk);
      end
      ok = (o_rvalid === 1'b1);
      d = o_rdata;
   endtask : rd
endmodule : scotp_host

/* scotp_pkg.sv */
/*
 * Shared constants for the current-sense configuration and fuse program
 * command registers: offsets, field positions, reset values and encodings.
 * Assumes a 16-bit register word and a 6-bit register address from the
 * serial register interface.
 */
package scotp_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int unsigned REG_W = 16;
   localparam int unsigned ADDR_W = 6;
   // Sense configuration offset is a local choice of this block
   localparam logic [5:0] SENSE_CFG_ADDR = 6'h0C;
   localparam logic [5:0] FUSE_PROG_ADDR = 6'h1F;
   localparam logic [15:0] SENSE_CFG_RESET = 16'h0833;
   localparam logic [15:0] FUSE_PROG_RESET = 16'h0000;

   // ****************************************
   // Sense configuration fields
   // ****************************************
   localparam int unsigned LATCH_BIT = 8;
   localparam int unsigned MODE_BIT = 9;
   localparam int unsigned BRAKE_BIT = 10;
   localparam int unsigned TRUNC_BIT = 11;
   localparam int unsigned VREF_BIT = 12;
   localparam int unsigned NEG_BIT = 13;
   localparam int unsigned AZ_LSB = 14;
   localparam logic [7:0] LOW_FIELDS_RESET = 8'h33;

   // ****************************************
   // Fuse program fields
   // ****************************************
   localparam int unsigned TRIG_BIT = 0;
   localparam int unsigned TAG_LSB = 1;
   localparam int unsigned TAG_W = 4;

   // ****************************************
   // Encodings
   // ****************************************
   typedef enum logic [1:0] {
      AZ_INT_SYNC = 2'h0,
      AZ_OFF = 2'h1,
      AZ_EXT_SYNC = 2'h2,
      AZ_EXT_CPGATE = 2'h3
   } scotp_az_t;

   typedef enum logic [1:0] {
      TMODE_LOW_GATE_ON = 2'h0,
      TMODE_OTHER = 2'h1
   } scotp_tmode_t;

endpackage : scotp_pkg

/* scotp_regs.sv */
/*
 * Sense configuration and fuse program command register bank. Holds the
 * upper sense fields and the fuse program register, decodes them into
 * control levels for the sense amplifiers, fault logic and fuse sequencer.
 * Assumes a register write/read port already decoded from the serial
 * interface on i_mclk, and a brake mode field supplied by the PWM
 * configuration logic on the same clock.
 */
//
// Function
// - Bit 9 selects shunt or on-resistance sensing
// - Bit 10 brakes on overcurrent, forces latching
// - Brake uses PWM configuration braking mode
// - Bit 11 disables PWM truncation only
// - Bit 12 picks internal or external reference
// - Bit 13 suppresses negative overcurrent fully
// - Bits 15:14 select auto-zero mode
// - Auto-zero 11 also gates charge pump
// - Writing bit 0 at 1F starts programming
// - Bits 4:1 hold readable user tag
// - Bits 15:5 reserved, read zero
// - Bit 8 selects latched overcurrent fault
module scotp_regs
   import scotp_pkg::*;
#(
   parameter int unsigned BRAKE_MODE_W = 2
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // Register port
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [scotp_pkg::ADDR_W-1:0] i_addr,
   input wire logic [scotp_pkg::REG_W-1:0] i_wdata,
   output logic [scotp_pkg::REG_W-1:0] o_rdata,
   output logic o_rvalid,
   // Fault, brake and timing select inputs
   input wire logic [BRAKE_MODE_W-1:0] i_pwm_brake_mode,
   input wire logic i_pos_ocp_raw,
   input wire logic i_neg_ocp_raw,
   input wire logic [1:0] i_tmode_req,
   // Sense controls
   output logic o_rdson_mode,
   output logic [1:0] o_sense_timing_select,
   output logic o_overcurrent_latch_eff,
   output logic o_overcurrent_brake_enable,
   output logic [BRAKE_MODE_W-1:0] o_brake_mode,
   output logic o_truncation_disable,
   output logic o_offset_ref_select,
   output logic o_negative_overcurrent_disable,
   output logic o_pwm_truncate,
   output logic o_ocp_fault_event,
   output logic o_autozero_enable,
   output logic o_autozero_ext_sync,
   output logic o_cp_clock_gate,
   // Fuse programming
   output logic o_fuse_program_trigger,
   output logic [scotp_pkg::TAG_W-1:0] o_user_tag
);

   // ****************************************
   // Register state
   // ****************************************
   logic [7:0] sense_hi;
   logic [7:0] next_sense_hi;
   logic [TAG_W-1:0] user_tag;
   logic [TAG_W-1:0] next_user_tag;
   logic trig;
   logic next_trig;
   logic [REG_W-1:0] rdata;
   logic [REG_W-1:0] next_rdata;
   logic rvalid;
   logic next_rvalid;
   logic wr_sense;
   logic wr_fuse;

   // Lower threshold fields belong to other logic; they read as reset here
   function automatic logic [REG_W-1:0] read_word(input logic [ADDR_W-1:0] a,
                                                  input logic [7:0] hi,
                                                  input logic [TAG_W-1:0] tag);
      logic [REG_W-1:0] w;
      w = 16'h0000;
      if (a == SENSE_CFG_ADDR) begin
         w = {hi, LOW_FIELDS_RESET};
      end else if (a == FUSE_PROG_ADDR) begin
         w[TAG_LSB +: TAG_W] = tag;
      end
      return w;
   endfunction : read_word

   assign wr_sense = i_wr_en && (i_addr == SENSE_CFG_ADDR);
   assign wr_fuse = i_wr_en && (i_addr == FUSE_PROG_ADDR);

   always_comb begin
      next_sense_hi = sense_hi;
      next_user_tag = user_tag;
      next_trig = 1'b0;
      next_rvalid = i_rd_en;
      next_rdata = rdata;
      if (wr_sense) begin
         next_sense_hi = i_wdata[REG_W-1:8];
      end
      if (wr_fuse) begin
         next_user_tag = i_wdata[TAG_LSB +: TAG_W];
         next_trig = i_wdata[TRIG_BIT];
      end
      if (i_rd_en) begin
         next_rdata = read_word(i_addr, sense_hi, user_tag);
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sense_hi <= SENSE_CFG_RESET[REG_W-1:8];
         user_tag <= FUSE_PROG_RESET[TAG_LSB +: TAG_W];
         trig <= 1'b0;
         rdata <= 16'h0000;
         rvalid <= 1'b0;
      end else begin
         sense_hi <= next_sense_hi;
         user_tag <= next_user_tag;
         trig <= next_trig;
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   // ****************************************
   // Field decode
   // ****************************************
   logic f_latch;
   logic f_mode;
   logic f_brake;
   logic f_trunc;
   logic f_vref;
   logic f_neg;

   assign f_latch = sense_hi[LATCH_BIT-8];
   assign f_mode = sense_hi[MODE_BIT-8];
   assign f_brake = sense_hi[BRAKE_BIT-8];
   assign f_trunc = sense_hi[TRUNC_BIT-8];
   assign f_vref = sense_hi[VREF_BIT-8];
   assign f_neg = sense_hi[NEG_BIT-8];

   scotp_autozero_decode u_az (
      .i_sel(sense_hi[AZ_LSB-8 +: 2]),
      .o_enable(o_autozero_enable),
      .o_ext_sync(o_autozero_ext_sync),
      .o_cp_gate(o_cp_clock_gate)
   );

   // ****************************************
   // Overcurrent path
   // ****************************************
   // Raw comparator outputs are asynchronous to i_mclk; two stages each
   logic [1:0] pos_sync;
   logic [1:0] neg_sync;
   logic [1:0] next_pos_sync;
   logic [1:0] next_neg_sync;
   logic neg_ocp;
   logic any_ocp;

   always_comb begin
      next_pos_sync = {pos_sync[0], i_pos_ocp_raw};
      next_neg_sync = {neg_sync[0], i_neg_ocp_raw};
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pos_sync <= 2'h0;
         neg_sync <= 2'h0;
      end else begin
         pos_sync <= next_pos_sync;
         neg_sync <= next_neg_sync;
      end
   end

   assign neg_ocp = neg_sync[1] && !f_neg;
   assign any_ocp = pos_sync[1] || neg_ocp;

   // ****************************************
   // Registered outputs
   // ****************************************
   logic [1:0] tmode;
   logic [1:0] next_tmode;
   logic trunc_out;
   logic next_trunc_out;
   logic fault_out;
   logic next_fault_out;
   logic [BRAKE_MODE_W-1:0] bmode;
   logic [BRAKE_MODE_W-1:0] next_bmode;

   always_comb begin
      // On-resistance sensing only works while the low gate conducts
      next_tmode = f_mode ? TMODE_LOW_GATE_ON : i_tmode_req;
      next_trunc_out = any_ocp && !f_trunc;
      // Fault reporting does not depend on truncation setting
      next_fault_out = any_ocp;
      next_bmode = f_brake ? i_pwm_brake_mode : bmode;
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tmode <= TMODE_LOW_GATE_ON;
         trunc_out <= 1'b0;
         fault_out <= 1'b0;
         bmode <= '0;
      end else begin
         tmode <= next_tmode;
         trunc_out <= next_trunc_out;
         fault_out <= next_fault_out;
         bmode <= next_bmode;
      end
   end

   assign o_rdson_mode = f_mode;
   assign o_sense_timing_select = tmode;
   assign o_overcurrent_brake_enable = f_brake;
   assign o_overcurrent_latch_eff = f_latch || f_brake;
   assign o_brake_mode = bmode;
   assign o_truncation_disable = f_trunc;
   assign o_offset_ref_select = f_vref;
   assign o_negative_overcurrent_disable = f_neg;
   assign o_pwm_truncate = trunc_out;
   assign o_ocp_fault_event = fault_out;
   assign o_fuse_program_trigger = trig;
   assign o_user_tag = user_tag;
   assign o_rdata = rdata;
   assign o_rvalid = rvalid;

endmodule : scotp_regs

/* scotp_regs_bench.sv */
/* Self-checking bench for scotp_regs.
   Assumes scotp_host and the checker beside it. */
module scotp_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import scotp_pkg::*;
   logic i_mclk, i_arst_n, i_wr_en, i_rd_en, i_pos_ocp_raw, i_neg_ocp_raw, o_rvalid;
   logic [5:0] i_addr;
   logic [15:0] i_wdata, o_rdata;
   logic [1:0] i_pwm_brake_mode, i_tmode_req, o_sense_timing_select, o_brake_mode;
   logic [3:0] o_user_tag;
   logic o_rdson_mode, o_overcurrent_latch_eff, o_overcurrent_brake_enable, o_truncation_disable;
   logic o_offset_ref_select, o_negative_overcurrent_disable, o_pwm_truncate, o_ocp_fault_event;
   logic o_autozero_enable, o_autozero_ext_sync, o_cp_clock_gate, o_fuse_program_trigger;
   int mismatches = 0;
   int tests_run = 0;
   wire logic [5:0] flags = {o_overcurrent_latch_eff, o_rdson_mode, o_overcurrent_brake_enable,
                             o_truncation_disable, o_offset_ref_select, o_negative_overcurrent_disable};
   wire logic [15:0] ocp = {14'h0000, o_pwm_truncate, o_ocp_fault_event};
   scotp_regs DUT (.*);
   scotp_host HOST (.*);
   // ****************************************
   // Checking
   // ****************************************
   task automatic complete_run();
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      HOST.rd(a, d, ok);
      if (!ok) begin
         mismatches++;
         complete_run();
      end else begin
         chk(d, exp);
      end
   endtask : rd_chk
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic test_sense();
      int b;
      logic [15:0] v;
      for (b = 8; b <= 13; b++) begin
         v = (16'h0001 << b) | 16'h0033;
         HOST.wr(SENSE_CFG_ADDR, v);
         rd_chk(SENSE_CFG_ADDR, v);
         chk({10'h000, flags}, {10'h000, b == 8 || b == 10, b == 9, b == 10, b == 11, b == 12, b == 13});
         chk(16'(o_sense_timing_select), (b == 9) ? 16'h0000 : 16'h0003);
         chk(16'(o_brake_mode), (b >= 10) ? 16'h0002 : 16'h0000);
      end
      // Brake on, shunt mode: both outputs must track their live inputs
      HOST.wr(SENSE_CFG_ADDR, 16'h0433);
      i_pwm_brake_mode = 2'h1;
      i_tmode_req = 2'h1;
      repeat (2) @(negedge i_mclk);
      chk(16'(o_brake_mode), 16'h0001);
      chk(16'(o_sense_timing_select), 16'h0001);
      i_pwm_brake_mode = 2'h2;
      i_tmode_req = 2'h3;
      repeat (2) @(negedge i_mclk);
   endtask : test_sense
   task automatic test_autozero();
      int z;
      for (z = 0; z < 4; z++) begin
         HOST.wr(SENSE_CFG_ADDR, {z[1:0], 14'h0033});
         chk({13'h0000, o_autozero_enable, o_autozero_ext_sync, o_cp_clock_gate}, {13'h0000, z != 1, z >= 2, z == 3});
      end
   endtask : test_autozero
   task automatic test_ocp();
      HOST.wr(SENSE_CFG_ADDR, 16'h0033);
      i_neg_ocp_raw = 1'b1;
      repeat (5) @(negedge i_mclk);
      chk(ocp, 16'h0003);
      HOST.wr(SENSE_CFG_ADDR, 16'h2033);
      repeat (5) @(negedge i_mclk);
      chk(ocp, 16'h0000);
      i_pos_ocp_raw = 1'b1;
      HOST.wr(SENSE_CFG_ADDR, 16'h2833);
      repeat (5) @(negedge i_mclk);
      chk(ocp, 16'h0001);
      i_pos_ocp_raw = 1'b0;
      i_neg_ocp_raw = 1'b0;
   endtask : test_ocp
   task automatic test_fuse();
      HOST.wr(FUSE_PROG_ADDR, 16'hFFFF);
      chk(16'(o_fuse_program_trigger), 16'h0001);
      @(negedge i_mclk);
      chk(16'(o_fuse_program_trigger), 16'h0000);
      chk(16'(o_user_tag), 16'h000F);
      rd_chk(FUSE_PROG_ADDR, 16'h001E);
      HOST.wr(FUSE_PROG_ADDR, 16'h0012);
      chk(16'(o_fuse_program_trigger), 16'h0000);
      HOST.wr(6'h05, 16'hFFFF);
      rd_chk(6'h05, 16'h0000);
      rd_chk(FUSE_PROG_ADDR, 16'h0012);
   endtask : test_fuse
   task automatic test_reset();
      HOST.wr(FUSE_PROG_ADDR, 16'h001F);
      HOST.wr(SENSE_CFG_ADDR, 16'hFF33);
      @(negedge i_mclk);
      i_arst_n = 1'b0;
      repeat (2) @(negedge i_mclk);
      i_arst_n = 1'b1;
      chk(16'(o_fuse_program_trigger), 16'h0000);
      chk({10'h000, flags}, 16'h0004);
      chk(16'(o_brake_mode), 16'h0000);
      rd_chk(SENSE_CFG_ADDR, SENSE_CFG_RESET);
      rd_chk(FUSE_PROG_ADDR, FUSE_PROG_RESET);
   endtask : test_reset
   initial begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end
   initial begin
      i_arst_n = 1'b0;
      i_pos_ocp_raw = 1'b0;
      i_neg_ocp_raw = 1'b0;
      i_tmode_req = 2'h3;
      i_pwm_brake_mode = 2'h2;
      repeat (20) @(negedge i_mclk);
      i_arst_n = 1'b1;
      rd_chk(SENSE_CFG_ADDR, SENSE_CFG_RESET);
      rd_chk(FUSE_PROG_ADDR, FUSE_PROG_RESET);
      test_sense();
      test_autozero();
      test_ocp();
      test_fuse();
      test_reset();
      complete_run();
   end
endmodule : scotp_regs_bench
bind scotp_regs scotp_regs_checker #(.BRAKE_MODE_W(BRAKE_MODE_W)) CHK (.*);

/* scotp_regs_checker.sv */
/* Port checker for scotp_regs.
   Assumes a bind onto scotp_regs. */
module scotp_regs_checker
   import scotp_pkg::*;
#(
   parameter int unsigned BRAKE_MODE_W = 2
) (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [5:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic [15:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic [BRAKE_MODE_W-1:0] i_pwm_brake_mode,
   input wire logic i_pos_ocp_raw,
   input wire logic [1:0] i_tmode_req,
   input wire logic o_rdson_mode,
   input wire logic [1:0] o_sense_timing_select,
   input wire logic o_overcurrent_latch_eff,
   input wire logic o_overcurrent_brake_enable,
   input wire logic [BRAKE_MODE_W-1:0] o_brake_mode,
   input wire logic o_truncation_disable,
   input wire logic o_negative_overcurrent_disable,
   input wire logic o_pwm_truncate,
   input wire logic o_ocp_fault_event,
   input wire logic o_autozero_enable,
   input wire logic o_autozero_ext_sync,
   input wire logic o_cp_clock_gate,
   input wire logic o_fuse_program_trigger,
   input wire logic [3:0] o_user_tag
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   wire logic fuse_wr = i_wr_en && i_addr == FUSE_PROG_ADDR;
   wire logic fuse_go = fuse_wr && i_wdata[0];
   wire logic [3:0] wtag = i_wdata[4:1];
   AST_TSEL_FORCE: assert property (o_rdson_mode |=> o_sense_timing_select == 2'h0)
      else $error("timing select not forced");
   AST_TSEL_PASS: assert property (!o_rdson_mode |=> o_sense_timing_select == $past(i_tmode_req))
      else $error("timing select not passed");
   AST_LATCH: assert property (o_overcurrent_brake_enable |-> o_overcurrent_latch_eff)
      else $error("brake without latch");
   AST_BRAKE: assert property (o_overcurrent_brake_enable |=> o_brake_mode == $past(i_pwm_brake_mode))
      else $error("brake mode not followed");
   AST_TRUNC: assert property (o_truncation_disable [*5] |-> !o_pwm_truncate)
      else $error("truncation while disabled");
   AST_FAULT: assert property (i_pos_ocp_raw [*5] |-> o_ocp_fault_event)
      else $error("fault missing");
   AST_NEG: assert property ((o_negative_overcurrent_disable && !i_pos_ocp_raw) [*5] |-> !o_ocp_fault_event)
      else $error("negative fault not masked");
   AST_AZ: assert property (o_autozero_ext_sync |-> o_autozero_enable)
      else $error("ext sync without autozero");
   AST_CPG: assert property (o_cp_clock_gate |-> o_autozero_ext_sync)
      else $error("gating without ext sync");
   AST_TRIG: assert property (fuse_go |=> o_fuse_program_trigger)
      else $error("trigger missing");
   AST_STRIKE: assert property (o_fuse_program_trigger |-> $past(fuse_go))
      else $error("trigger without strike");
   AST_TAG: assert property (fuse_wr |=> o_user_tag == $past(wtag))
      else $error("tag not stored");
   AST_RSVD: assert property (i_rd_en && i_addr == FUSE_PROG_ADDR |=> o_rvalid && o_rdata[15:5] == 11'h000 && !o_rdata[0])
      else $error("reserved bits not zero");
   cover property (fuse_go);
   cover property (o_pwm_truncate);
   cover property (o_cp_clock_gate);
endmodule : scotp_regs_checker
